// File: rtl/pssp_pkg.sv
// How it works
// - Third chip select, active low, sampled
// - Missing third select acts as asserted
// - Output enable async; high floats data pins
// - First read after deselect keeps pins undriven
// - Advance low during burst steps address
// - Processor strobe captures address, loads counter
// - Controller strobe captures address, loads counter
// - Both strobes: only processor strobe acts
// - Processor strobe ignored when first select high
// - Sleep input high: idle, contents kept
// - Sleep must be low for operation
// - Write data registered at rising edge
// - Read data follows address by one cycle
// - Burst-order strap: low linear, high interleaved
// - Global write low writes all bytes
// - Byte write needs enable and byte selects
// - Second chip select, active high, sampled
package pssp_pkg;
	localparam int ADDR_W   = 8;
	localparam int BYTES    = 2;
	localparam int LANE_W   = 9;
	localparam int DATA_W   = BYTES * LANE_W;
	localparam int DEPTH    = 1 << ADDR_W;
	localparam int BURST_W  = 2;
	localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;
	localparam logic [ADDR_W-1:0]  ADDR_RST  = 8'h00;
	localparam logic [DATA_W-1:0]  DATA_RST  = 18'h00000;
endpackage : pssp_pkg

// File: rtl/pssp_sram_port.sv
`timescale 1ns/1ps
module pssp_sram_port #(
	parameter bit HAS_THIRD_SELECT = 1'b1
) (
	input  wire logic                          clk_sys,
	input  wire logic                          sys_rst,
	input  wire logic [pssp_pkg::ADDR_W-1:0]  addrIn,
	input  wire logic                          chip_select_first_n,
	input  wire logic                          chip_select_second,
	input  wire logic                          chip_select_third_n,
	input  wire logic                          processor_addr_strobe_n,
	input  wire logic                          controller_addr_strobe_n,
	input  wire logic                          burst_advance_n,
	input  wire logic                          global_write_n,
	input  wire logic                          byte_write_enable_n,
	input  wire logic [pssp_pkg::BYTES-1:0]   byte_select_n,
	input  wire logic                          output_enable_n,
	input  wire logic                          sleep_request,
	input  wire logic                          burstModeStrap,
	input  wire logic [pssp_pkg::DATA_W-1:0]  dataIn,
	output logic      [pssp_pkg::DATA_W-1:0]  dataOut,
	output logic      [pssp_pkg::DATA_W-1:0]  dataOutEn_n
);
	// ----------------------------------------------------------------
	// Access decode
	// ----------------------------------------------------------------
	logic [pssp_pkg::DATA_W-1:0] memArray [pssp_pkg::DEPTH];
	logic [pssp_pkg::ADDR_W-1:0] baseAddr_ff, nxt_baseAddr;
	logic [pssp_pkg::BURST_W-1:0] burstCnt_ff, nxt_burstCnt;
	logic [pssp_pkg::DATA_W-1:0] readData_ff, nxt_readData;
	logic                        active_ff, nxt_active;
	logic                        readOut_ff, nxt_readOut;
	logic                        wasDesel_ff, nxt_wasDesel;
	logic                        firstRead_ff, nxt_firstRead;
	logic                        modeLin_ff, nxt_modeLin;
	logic                        third_n, selected, procStb, ctrlStb, strobe, writeReq;
	logic [pssp_pkg::BYTES-1:0]  byteWr;
	logic [pssp_pkg::BURST_W-1:0] curLow;
	logic [pssp_pkg::BURST_W-1:0] advCnt;
	logic [pssp_pkg::ADDR_W-1:0] curAddr;

	always_comb
	begin
		third_n  = HAS_THIRD_SELECT ? chip_select_third_n : 1'b0;
		selected = !chip_select_first_n && chip_select_second && !third_n;
		procStb  = !processor_addr_strobe_n && !chip_select_first_n;
		ctrlStb  = !controller_addr_strobe_n && !procStb;
		strobe   = procStb || ctrlStb;
		// A processor strobe is a read start; writes follow on later cycles
		writeReq = !global_write_n || !byte_write_enable_n;
		byteWr   = !global_write_n ? '1 :
			(!byte_write_enable_n ? ~byte_select_n : '0);
		if (procStb)
			byteWr = '0;
		if (sleep_request)
			byteWr = '0;
		// Advance steps the address of this very beat, not of the next one
		advCnt   = burstCnt_ff;
		if (active_ff && !burst_advance_n && !strobe && !sleep_request)
			advCnt = burstCnt_ff + pssp_pkg::BURST_ONE;
		curLow   = modeLin_ff ? baseAddr_ff[pssp_pkg::BURST_W-1:0] + advCnt
			: baseAddr_ff[pssp_pkg::BURST_W-1:0] ^ advCnt;
		curAddr  = {baseAddr_ff[pssp_pkg::ADDR_W-1:pssp_pkg::BURST_W], curLow};
		if (strobe && selected && !sleep_request)
			curAddr = addrIn;
	end

	// ----------------------------------------------------------------
	// Address, burst and pipeline state
	// ----------------------------------------------------------------
	always_comb
	begin
		nxt_baseAddr  = baseAddr_ff;
		nxt_burstCnt  = burstCnt_ff;
		nxt_active    = active_ff;
		nxt_modeLin   = modeLin_ff;
		nxt_readOut   = 1'b0;
		nxt_readData  = readData_ff;
		nxt_wasDesel  = wasDesel_ff;
		nxt_firstRead = 1'b0;
		if (!sleep_request)
		begin
			if (strobe && selected)
			begin
				nxt_baseAddr = addrIn;
				nxt_burstCnt = '0;
				nxt_active   = 1'b1;
				nxt_modeLin  = !burstModeStrap;
			end
			else if (strobe)
			begin
				nxt_active = 1'b0;
			end
			else if (active_ff && !burst_advance_n)
			begin
				nxt_burstCnt = advCnt;
			end
			if (nxt_active && !(writeReq && !procStb))
			begin
				nxt_readOut   = 1'b1;
				nxt_readData  = memArray[curAddr];
				nxt_firstRead = wasDesel_ff;
			end
			nxt_wasDesel = !nxt_active;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			baseAddr_ff  <= pssp_pkg::ADDR_RST;
			burstCnt_ff  <= '0;
			active_ff    <= 1'b0;
			modeLin_ff   <= 1'b0;
			readOut_ff   <= 1'b0;
			readData_ff  <= pssp_pkg::DATA_RST;
			wasDesel_ff  <= 1'b1;
			firstRead_ff <= 1'b0;
		end
		else
		begin
			baseAddr_ff  <= nxt_baseAddr;
			burstCnt_ff  <= nxt_burstCnt;
			active_ff    <= nxt_active;
			modeLin_ff   <= nxt_modeLin;
			readOut_ff   <= nxt_readOut;
			readData_ff  <= nxt_readData;
			wasDesel_ff  <= nxt_wasDesel;
			firstRead_ff <= nxt_firstRead;
		end
	end

	// ----------------------------------------------------------------
	// Storage: no reset, contents survive sleep and reset alike
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		for (int b = 0; b < pssp_pkg::BYTES; b++)
			if (nxt_active && byteWr[b])
				memArray[curAddr][b*pssp_pkg::LANE_W +: pssp_pkg::LANE_W]
					<= dataIn[b*pssp_pkg::LANE_W +: pssp_pkg::LANE_W];
	end

	// ----------------------------------------------------------------
	// Pins: enable is combinational so output enable acts at once
	// ----------------------------------------------------------------
	always_comb
	begin
		dataOut     = readData_ff;
		dataOutEn_n = (!output_enable_n && readOut_ff && !firstRead_ff)
			? '0 : '1;
	end
endmodule : pssp_sram_port

// File: tb/pssp_host.sv
`timescale 1ns/1ps
module pssp_host (
	input  wire logic clk_sys,
	output logic [7:0] addrIn = 8'h00,
	output logic [17:0] dataIn = 18'h00000,
	output logic processor_addr_strobe_n = 1, controller_addr_strobe_n = 1, burst_advance_n = 1,
	output logic global_write_n = 1, chip_select_second = 1, chip_select_third_n = 0,
	output logic sleep_request = 0, output_enable_n = 0, burstModeStrap = 0,
	output logic chip_select_first_n = 0, byte_write_enable_n = 1,
	output logic [1:0] byte_select_n = 2'h3
);
	logic mode = 0;
	// Kinds: 0 idle, 1 read, 2 write, 3 deselect, 4 advance, 5 both strobes, 6 sleep write,
	// 7 byte write with lane selects from the top data bits
	task automatic op(input logic [2:0] k, input logic [7:0] a, input logic [17:0] d);
		@(posedge clk_sys);
		addrIn <= a;
		dataIn <= (k == 2 || k >= 5) ? d : ~dataIn;
		processor_addr_strobe_n <= !(k == 1 || k == 5);
		controller_addr_strobe_n <= !(k == 2 || k == 3 || k >= 5);
		global_write_n <= !(k == 2 || k == 5 || k == 6);
		byte_write_enable_n <= k != 7;
		byte_select_n <= d[17:16];
		burst_advance_n <= k != 4;
		chip_select_second <= !(k == 3 && !d[0]);
		chip_select_third_n <= k == 3 && d[0];
		sleep_request <= k == 6;
		output_enable_n <= k == 0 && d[0];
		burstModeStrap <= mode;
	endtask : op
endmodule : pssp_host

// File: tb/pssp_props.sv
`timescale 1ns/1ps
module pssp_props (
	input wire logic clk_sys, sys_rst, chip_select_first_n, chip_select_second,
	input wire logic chip_select_third_n, processor_addr_strobe_n, controller_addr_strobe_n,
	input wire logic global_write_n, output_enable_n, sleep_request,
	input wire logic [pssp_pkg::ADDR_W-1:0] addrIn,
	input wire logic [pssp_pkg::DATA_W-1:0] dataIn, dataOut, dataOutEn_n
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	wire sel = !chip_select_first_n && chip_select_second && !chip_select_third_n && !sleep_request;
	wire rd = sel && !processor_addr_strobe_n;
	wire wr = sel && processor_addr_strobe_n && !controller_addr_strobe_n && !global_write_n;
	wire ds = !controller_addr_strobe_n && !sleep_request && (chip_select_third_n || !chip_select_second);
	logic [pssp_pkg::ADDR_W-1:0] prevAddr;
	always @(posedge clk_sys) prevAddr <= addrIn;
	wire same = addrIn == prevAddr;
	property p_oe; output_enable_n |-> &dataOutEn_n; endproperty
	a_oe: assert property (p_oe) else $error("driving with oe high");
	property p_lane; dataOutEn_n == '0 || &dataOutEn_n; endproperty
	a_lane: assert property (p_lane) else $error("lanes split");
	property p_drv; rd ##1 rd |=> output_enable_n || dataOutEn_n == '0; endproperty
	a_drv: assert property (p_drv) else $error("read not driven");
	property p_first; ds ##1 rd |=> &dataOutEn_n; endproperty
	a_first: assert property (p_first) else $error("driven after deselect");
	property p_zz; sleep_request [*2] |-> $stable(dataOut); endproperty
	a_zz: assert property (p_zz) else $error("output moved in sleep");
	property p_wr; wr ##1 (rd && same) |=> dataOut == $past(dataIn, 2); endproperty
	a_wr: assert property (p_wr) else $error("write then read");
	property p_both; wr ##1 (rd && !controller_addr_strobe_n && same) ##1 (rd && same)
		|=> dataOut == $past(dataIn, 3); endproperty
	a_both: assert property (p_both) else $error("both strobes wrote");
	property p_slp; wr ##1 (sleep_request && !global_write_n && same) ##1 (rd && same)
		|=> dataOut == $past(dataIn, 3); endproperty
	a_slp: assert property (p_slp) else $error("write in sleep");
	c_first: cover property (ds ##1 rd);
	c_wr: cover property (wr ##1 rd);
	c_zz: cover property (sleep_request [*2]);
endmodule : pssp_props
bind pssp_sram_port pssp_props i_props (.*);

// File: tb/tb_pipelined_sync_sram_port.sv
`timescale 1ns/1ps
module tb_pipelined_sync_sram_port;
	logic clk_sys = 0, sys_rst = 1, md, chk = 0;
	wire logic [7:0] addrIn;
	wire logic [17:0] dataIn, dataOut, dataOutEn_n;
	wire logic [1:0] byte_select_n;
	wire logic processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n, global_write_n;
	wire logic chip_select_second, chip_select_third_n, sleep_request, output_enable_n;
	wire logic burstModeStrap, chip_select_first_n, byte_write_enable_n;
	int num_errors = 0, n_compared = 0, cyc = 0, k, lastk = 0;
	logic [17:0] exp, m [256];
	logic [7:0] ba;
	logic [1:0] cnt;
	pssp_sram_port i_dut (.*);
	pssp_host i_host (.*);
	always #50 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (++cyc == 2000) begin num_errors++; finish_test(); end
	task automatic finish_test;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test
	task automatic cmp(input logic [17:0] got, input logic [17:0] want);
		n_compared++;
		if (got !== want)
			begin num_errors++; $display("CHECK FAILED %0t got %h exp %h", $time, got, want); end
	endtask : cmp
	// Burst address: linear adds, interleaved flips, both wrap in four
	task automatic step(input logic [2:0] s, input logic [7:0] a, input logic [17:0] d);
		i_host.op(s, a, d);
		#1;
		if (chk)
			cmp(dataOut, exp);
		chk = s inside {1, 4, 5} && lastk != 3;
		lastk = s;
		if (s == 2)
			m[a] = d;
		if (s == 7 && !d[16])
			m[a][8:0] = d[8:0];
		if (s == 7 && !d[17])
			m[a][17:9] = d[17:9];
		if (s == 1 || s == 5)
			begin ba = a; cnt = 0; md = i_host.mode; end
		if (s == 4)
			cnt++;
		exp = m[{ba[7:2], md ? ba[1:0] ^ cnt : ba[1:0] + cnt}];
	endtask : step
	initial begin
		void'($urandom(6));
		repeat (12) @(posedge clk_sys);
		sys_rst <= 0;
		for (int i = 0; i < 256; i++) step(2, 8'(i), 18'($urandom));
		for (int i = 0; i < 2; i++) begin
			i_host.mode = i[0];
			step(1, 8'h13 + 8'(i), 0);
			repeat (4) step(4, 0, 0);
		end
		step(2, 8'h40, 18'h2aaaa);
		step(5, 8'h40, 18'h15555);
		step(1, 8'h40, 0);
		step(2, 8'h41, 18'h12345);
		step(6, 8'h41, 18'h0abcd);
		step(1, 8'h41, 0);
		repeat (600) begin
			k = $urandom_range(7);
			if (k == 4 && !(lastk inside {1, 4, 5})) k = 1;
			step(3'(k), 8'($urandom), 18'($urandom));
		end
		step(0, 0, 0);
		finish_test();
	end
endmodule : tb_pipelined_sync_sram_port
